/* common/glm_pkg.sv */
// Package of constants for the global line mode and impedance control block.
package glm_pkg;
	// ==========================================================================
	// Geometry
	// ==========================================================================
	localparam int unsigned CHANNELS    = 16;
	localparam int unsigned TERM_W      = 3;
	// ==========================================================================
	// Register map (word offsets are byte addresses)
	// ==========================================================================
	localparam logic [7:0] ADDR_STD    = 8'h00;
	localparam logic [7:0] ADDR_TERM   = 8'h04;
	localparam logic [7:0] ADDR_R120   = 8'h08;
	localparam logic [7:0] ADDR_DRV    = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_EFFSTD = 8'h14;
	localparam logic [7:0] ADDR_RXZ    = 8'h18;
	// ==========================================================================
	// Status field positions; the status read data puts diff at bit 5 and vcom at bit 4, the reverse of ST_DIFF and ST_VCOM
	// ==========================================================================
	localparam int unsigned ST_OE      = 0;
	localparam int unsigned ST_HWE     = 1;
	localparam int unsigned ST_HW      = 2;
	localparam int unsigned ST_RIM     = 3;
	localparam int unsigned ST_DIFF    = 4;
	localparam int unsigned ST_VCOM    = 5;
	// ==========================================================================
	// Reset values
	// ==========================================================================
	localparam logic [15:0] STD_RST    = 16'h0000;
	localparam logic [15:0] DRV_RST    = 16'hFFFF;
	localparam logic [15:0] R120_RST   = 16'h0000;
	localparam logic [2:0]  TERM_RST   = 3'h0;
	localparam logic [31:0] UNMAPPED   = 32'h0000_0000;
	// Bus state machine encoding.
	typedef enum logic [0:0] {
		GLM_IDLE = 1'b0,
		GLM_DONE = 1'b1
	} glm_bus_t;
endpackage

/* core/glm_ctrl.sv */
// Global line mode, driver enable and receive impedance control with an Avalon-MM slave.
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module glm_ctrl
	import glm_pkg::*;
(
	// Clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         resetn_i,
	input  wire logic                         ce_i,
	// Static pins from the board
	input  wire logic                         rx_impedance_match_pin_i,
	input  wire logic                         line_driver_enable_pin_i,
	input  wire logic                         hw_standard_select_enable_i,
	input  wire logic                         hw_standard_select_i,
	input  wire logic                         common_mode_output_enable_i,
	input  wire logic                         rx_differential_i,
	// Avalon-MM slave
	input  wire logic [7:0]                   avs_address_i,
	input  wire logic                         avs_read_i,
	input  wire logic                         avs_write_i,
	input  wire logic [31:0]                  avs_writedata_i,
	input  wire logic [3:0]                   avs_byteenable_i,
	output logic      [31:0]                  avs_readdata_o,
	output logic                              avs_waitrequest_o,
	// Line side controls
	output logic      [glm_pkg::CHANNELS-1:0] channel_e1_mode_o,
	output logic      [glm_pkg::CHANNELS-1:0] tx_driver_enable_o,
	output logic      [glm_pkg::CHANNELS-1:0] rx_high_z_o,
	output logic      [glm_pkg::CHANNELS*glm_pkg::TERM_W-1:0] rx_term_select_o,
	output logic      [glm_pkg::CHANNELS-1:0] rx_internal_120ohm_o,
	output logic      [1:0]                   common_mode_outputs_o
);
	import glm_pkg::*;

	// ==========================================================================
	// Pin synchronisers
	// ==========================================================================
	// Pins are static straps but may be toggled by a protection controller.
	logic [5:0] pin_raw;
	logic [5:0] pin_s1_r;
	logic [5:0] pin_s2_r;
	assign pin_raw = {rx_differential_i, common_mode_output_enable_i, rx_impedance_match_pin_i,
		hw_standard_select_i, hw_standard_select_enable_i, line_driver_enable_pin_i};

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_s1_r <= 6'h00;
			pin_s2_r <= 6'h00;
		end else if (ce_i) begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
		end
	end

	logic oe_s, hwe_s, hw_s, rim_s, vcom_s, diff_s;
	assign oe_s   = pin_s2_r[0];
	// Open pins arrive as high through the pad pull-up, so open and high match.
	assign hwe_s  = pin_s2_r[1];
	assign hw_s   = pin_s2_r[2];
	assign rim_s  = pin_s2_r[3];
	assign vcom_s = pin_s2_r[4];
	assign diff_s = pin_s2_r[5];

	// ==========================================================================
	// Registers and bus slave
	// ==========================================================================
	logic [15:0]              std_r, std_nxt;
	logic [15:0]              drv_r, drv_nxt;
	logic [15:0]              r120_r, r120_nxt;
	logic [CHANNELS*TERM_W-1:0] term_r, term_nxt;
	logic [31:0]              rdata_r, rdata_nxt;
	glm_bus_t                 bus_r, bus_nxt;

	function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [15:0] res;
		res = old;
		if (be[0]) res[7:0] = wd[7:0];
		if (be[1]) res[15:8] = wd[15:8];
		return res;
	endfunction

	logic [CHANNELS-1:0] e1_eff;
	logic [CHANNELS-1:0] rxz_eff;
	logic [CHANNELS-1:0] drv_eff;
	logic                rx_ext_only;

	// The request is answered one cycle after it is seen; waitrequest is low then.
	always_comb begin
		std_nxt   = std_r;
		drv_nxt   = drv_r;
		r120_nxt  = r120_r;
		term_nxt  = term_r;
		rdata_nxt = rdata_r;
		bus_nxt   = GLM_IDLE;
		case (bus_r)
			GLM_IDLE: begin
				if (avs_write_i) begin
					bus_nxt = GLM_DONE;
					case (avs_address_i)
						ADDR_STD:  std_nxt  = be_merge(std_r, avs_writedata_i, avs_byteenable_i);
						ADDR_DRV:  drv_nxt  = be_merge(drv_r, avs_writedata_i, avs_byteenable_i);
						ADDR_R120: r120_nxt = be_merge(r120_r, avs_writedata_i, avs_byteenable_i);
						ADDR_TERM: begin
							// Term fields are packed 3 bits per channel, channels 0..9 here.
							for (int b = 0; b < 4; b++) begin
								if (avs_byteenable_i[b])
									for (int k = 0; k < 8; k++)
										if (b*8+k < 30)
											term_nxt[b*8+k] = avs_writedata_i[b*8+k];
							end
						end
						default: ;
					endcase
				end else if (avs_read_i) begin
					bus_nxt = GLM_DONE;
					case (avs_address_i)
						ADDR_STD:    rdata_nxt = {16'h0000, std_r};
						ADDR_DRV:    rdata_nxt = {16'h0000, drv_r};
						ADDR_R120:   rdata_nxt = {16'h0000, r120_r};
						ADDR_TERM:   rdata_nxt = {2'b00, term_r[29:0]};
						ADDR_STATUS: rdata_nxt = {26'h0, diff_s, vcom_s, rim_s, hw_s, hwe_s, oe_s};
						ADDR_EFFSTD: rdata_nxt = {16'h0000, e1_eff};
						ADDR_RXZ:    rdata_nxt = {16'h0000, rxz_eff};
						default:     rdata_nxt = UNMAPPED;
					endcase
				end
			end
			GLM_DONE: bus_nxt = GLM_IDLE;
			default:  bus_nxt = GLM_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			std_r   <= STD_RST;
			drv_r   <= DRV_RST;
			r120_r  <= R120_RST;
			term_r  <= '0;
			rdata_r <= 32'h0000_0000;
			bus_r   <= GLM_IDLE;
		end else if (ce_i) begin
			std_r   <= std_nxt;
			drv_r   <= drv_nxt;
			r120_r  <= r120_nxt;
			term_r  <= term_nxt;
			rdata_r <= rdata_nxt;
			bus_r   <= bus_nxt;
		end
	end

	// ==========================================================================
	// Line mode and impedance decisions
	// ==========================================================================
	assign rx_ext_only = diff_s & ~rim_s;

	logic [CHANNELS*TERM_W-1:0] term_eff;
	logic [CHANNELS-1:0]        r120_eff;
	logic [1:0]                 vcom_eff;
	assign vcom_eff = {2{vcom_s}};

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_ch
			// Hardware pin low selects E1, high or open selects T1/J1.
			assign e1_eff[g]  = hwe_s ? ~hw_s : std_r[g];
			// Driver gate only touches the output stage; register state keeps updating.
			assign drv_eff[g] = oe_s & drv_r[g];
			assign rxz_eff[g] = rx_ext_only;
			// Per-channel settings are masked while only external matching is allowed.
			assign term_eff[g*TERM_W +: TERM_W] = rx_ext_only ? TERM_RST : term_r[g*TERM_W +: TERM_W];
			assign r120_eff[g] = rx_ext_only ? 1'b0 : r120_r[g];
		end
	endgenerate

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			channel_e1_mode_o     <= '0;
			tx_driver_enable_o    <= '0;
			rx_high_z_o           <= '0;
			rx_term_select_o      <= '0;
			rx_internal_120ohm_o  <= '0;
			common_mode_outputs_o <= 2'h0;
			avs_readdata_o        <= 32'h0000_0000;
			avs_waitrequest_o     <= 1'b1;
		end else if (ce_i) begin
			channel_e1_mode_o     <= e1_eff;
			tx_driver_enable_o    <= drv_eff;
			rx_high_z_o           <= rxz_eff;
			rx_term_select_o      <= term_eff;
			rx_internal_120ohm_o  <= r120_eff;
			common_mode_outputs_o <= vcom_eff;
			avs_readdata_o        <= rdata_nxt;
			avs_waitrequest_o     <= ~(bus_r == GLM_IDLE && (avs_read_i || avs_write_i));
		end
	end

	// ==========================================================================
	// Assertions
	// ==========================================================================
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	rx_hz_all_a: assert property (ce_i && diff_s && !rim_s |=> ce_i |-> rx_high_z_o == 16'hFFFF)
		else $error("Receivers not all high impedance");
	term_mask_a: assert property (ce_i && diff_s && !rim_s |=> ce_i |-> rx_internal_120ohm_o == 16'h0000)
		else $error("120-ohm select not masked");
	term_pass_a: assert property (ce_i && !(diff_s && !rim_s) |=> ce_i |-> rx_term_select_o == $past(term_r))
		else $error("Termination not passed through");
	drv_gate_a: assert property (ce_i && !oe_s |=> ce_i |-> tx_driver_enable_o == 16'h0000)
		else $error("Drivers enabled while gate low");
	drv_pass_a: assert property (ce_i && oe_s |=> ce_i |-> tx_driver_enable_o == $past(drv_r))
		else $error("Driver enable lost with gate high");
	reg_keep_a: assert property (ce_i && !oe_s && bus_r == GLM_IDLE && avs_write_i && avs_address_i == ADDR_STD
		&& avs_byteenable_i == 4'hF |=> std_r[15:0] == $past(avs_writedata_i[15:0]))
		else $error("Register write blocked by driver gate");
	hw_mode_a: assert property (ce_i && hwe_s |=> ce_i |-> channel_e1_mode_o == {16{~$past(hw_s)}})
		else $error("Global mode not applied");
	ch_mode_a: assert property (ce_i && !hwe_s |=> ce_i |-> channel_e1_mode_o == $past(std_r))
		else $error("Per-channel mode not applied");
	// The first stage is cleared by reset, so no attempt may start on an edge that still saw reset low.
	pin_sync_a: assert property (resetn_i && ce_i ##1 ce_i ##1 ce_i
		|-> hwe_s == $past(hw_standard_select_enable_i, 2))
		else $error("Mode enable pin not synchronised");

	cov_ext_c:  cover property (diff_s && !rim_s ##1 rim_s);
	cov_hw_c:   cover property (hwe_s ##1 !hwe_s);
	cov_oe_c:   cover property (!oe_s ##1 oe_s);
	cov_rd_c:   cover property (avs_read_i && !avs_waitrequest_o);
endmodule

/* verification/glm_board.sv */
// Board strapping model that drives the static control pins of the block.
`timescale 1ns/10ps
module glm_board (
	// Strap choices made by the bench
	input  wire logic ctl_hwe_open_i,
	input  wire logic ctl_hw_open_i,
	input  wire logic ctl_rim_i,
	input  wire logic ctl_oe_i,
	input  wire logic ctl_diff_i,
	input  wire logic ctl_tless_i,
	// Pins toward the block
	output logic      hwe_pin_o,
	output logic      hw_pin_o,
	output logic      rim_pin_o,
	output logic      oe_pin_o,
	output logic      diff_o,
	output logic      vcom_en_o
);
	// ==========================================================================
	// Straps
	// ==========================================================================
	// An open strap reads high because of the pull-up, so open is modelled as 1.
	assign hwe_pin_o = ctl_hwe_open_i;
	assign hw_pin_o  = ctl_hw_open_i;
	assign rim_pin_o = ctl_rim_i;
	assign oe_pin_o  = ctl_oe_i;
	assign diff_o    = ctl_diff_i;
	// Common-mode outputs are only wanted for transformer-less differential receive.
	assign vcom_en_o = ctl_diff_i & ctl_tless_i;
endmodule

/* verification/test_glm_ctrl.sv */
// Self-checking testbench for the global line mode and impedance control block.
`timescale 1ns/10ps
module test_glm_ctrl;
	import glm_pkg::*;
	// ==========================================================================
	// Signals
	// ==========================================================================
	logic        clk_i    = 1'b0;
	logic        resetn_i = 1'b0;
	logic        ce       = 1'b1;
	logic [5:0]  strap    = 6'b111100;
	logic        hwe_p, hw_p, rim_p, oe_p, diff_p, vce_p;
	logic [7:0]  adr      = 8'h00;
	logic        rd       = 1'b0;
	logic        wr       = 1'b0;
	logic [31:0] wd       = 32'h0;
	logic [3:0]  be       = 4'h0;
	logic [31:0] rdat, q;
	logic        wreq;
	logic [15:0] e1, txe, hz, r120;
	logic [47:0] term;
	logic [1:0]  vcom;
	int          failures = 0;
	int          n_tests  = 0;
	int          cycles   = 0;

	glm_board board (.ctl_hwe_open_i(strap[5]), .ctl_hw_open_i(strap[4]), .ctl_rim_i(strap[3]),
		.ctl_oe_i(strap[2]), .ctl_diff_i(strap[1]), .ctl_tless_i(strap[0]), .hwe_pin_o(hwe_p),
		.hw_pin_o(hw_p), .rim_pin_o(rim_p), .oe_pin_o(oe_p), .diff_o(diff_p), .vcom_en_o(vce_p));
	glm_ctrl dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce), .rx_impedance_match_pin_i(rim_p),
		.line_driver_enable_pin_i(oe_p), .hw_standard_select_enable_i(hwe_p), .hw_standard_select_i(hw_p),
		.common_mode_output_enable_i(vce_p), .rx_differential_i(diff_p), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .channel_e1_mode_o(e1), .tx_driver_enable_o(txe),
		.rx_high_z_o(hz), .rx_term_select_o(term), .rx_internal_120ohm_o(r120), .common_mode_outputs_o(vcom));

	always #50 clk_i = ~clk_i;
	// ==========================================================================
	// Helpers
	// ==========================================================================
	task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
			failures++;
		end
	endtask
	// The master waits on waitrequest itself; only the global cycle ceiling ends a wait that never ends.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
		@(posedge clk_i);
		rd <= ~w;
		wr <= w;
		adr <= a;
		wd <= d;
		be <= b;
		do begin
			@(posedge clk_i);
		end while (wreq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	// Straps are {hwe open, hw open, rim, oe, diff, transformer-less}; five edges cover sync and output reg.
	task automatic pins(input logic [5:0] v);
		strap <= v;
		repeat (5) @(posedge clk_i);
	endtask
	// ==========================================================================
	// Scenarios
	// ==========================================================================
	task automatic t_mode();
		bus(1'b1, ADDR_STD, 32'h0000_A5C3, 4'h3);
		pins(6'b101100);
		chk("e1 global", 48'hFFFF, e1);
		pins(6'b111100);
		chk("t1 global", 48'h0, e1);
		pins(6'b011100);
		chk("per channel", 48'hA5C3, e1);
		pins(6'b001100);
		chk("hw ignored", 48'hA5C3, e1);
		bus(1'b0, ADDR_EFFSTD, 32'h0, 4'hF);
		chk("eff std", 48'hA5C3, q[15:0]);
	endtask
	task automatic t_drv();
		chk("drv reset", {32'h0, DRV_RST}, txe);
		bus(1'b1, ADDR_DRV, 32'h0000_0F0F, 4'h3);
		pins(6'b011100);
		chk("drv on", 48'h0F0F, txe);
		pins(6'b011000);
		chk("drv off", 48'h0, txe);
		bus(1'b1, ADDR_STD, 32'h0000_3C5A, 4'hF);
		bus(1'b0, ADDR_EFFSTD, 32'h0, 4'hF);
		chk("mode kept", 48'h3C5A, q[15:0]);
		bus(1'b0, ADDR_DRV, 32'h0, 4'hF);
		chk("drv reg", 48'h0F0F, q[15:0]);
	endtask
	// Pins change while the clock enable is low; nothing may move until it returns.
	task automatic t_hold();
		ce <= 1'b0;
		pins(6'b111100);
		chk("ce hold", 48'h3C5A, e1);
		ce <= 1'b1;
		pins(6'b111100);
		chk("ce run", 48'h0, e1);
	endtask
	// A reset in mid-run must bring registers back to their reset values.
	task automatic t_reset();
		resetn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk("rst wait", 48'h1, wreq);
		chk("rst mode", 48'h0, e1);
		resetn_i <= 1'b1;
		pins(6'b011100);
		chk("rst std", {32'h0, STD_RST}, e1);
		chk("rst drv", {32'h0, DRV_RST}, txe);
	endtask
	task automatic t_rim();
		bus(1'b1, ADDR_TERM, 32'h1234_5678, 4'hF);
		bus(1'b1, ADDR_R120, 32'h0000_8001, 4'h3);
		pins(6'b010110);
		chk("high z", 48'hFFFF, hz);
		chk("term off", 48'h0, term);
		chk("r120 off", 48'h0, r120);
		chk("vcom off", 48'h0, vcom);
		bus(1'b0, ADDR_RXZ, 32'h0, 4'hF);
		chk("rxz reg", 48'hFFFF, q[15:0]);
		pins(6'b011111);
		chk("high z off", 48'h0, hz);
		chk("term on", 48'h1234_5678, term);
		chk("r120 on", 48'h8001, r120);
		chk("vcom on", 48'h3, vcom);
	endtask
	task automatic t_misc();
		bus(1'b0, 8'hFC, 32'h0, 4'hF);
		chk("unmapped", 48'h0, q);
		bus(1'b1, ADDR_STATUS, 32'hFFFF_FFFF, 4'hF);
		bus(1'b0, ADDR_STATUS, 32'h0, 4'hF);
		chk("status", 48'h3D, q);
	endtask
	// ==========================================================================
	// Sequence and verdict
	// ==========================================================================
	task automatic give_verdict();
		if (failures == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			give_verdict();
		end
	end
	initial begin
		repeat (6) @(posedge clk_i);
		resetn_i <= 1'b1;
		t_mode();
		t_drv();
		t_hold();
		t_rim();
		t_misc();
		t_reset();
		give_verdict();
	end
endmodule
